// ### dv/irq_far_side.sv
/*
  Far-side model of the processor core and the transfer engine: emits the
  instruction-end beat, completes transfers and acknowledges offers.
  Assumes one clock shared with the dispatch block; latency comes from the bench.
*/
`timescale 1ns/1ps
module irq_far_side (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // requests from the dispatch block
   input  wire logic        xfer_req,
   input  wire logic        cpu_req,
   // behaviour knobs from the bench
   input  wire logic [3:0]  lat,
   input  wire logic        count_zero_cfg,
   // answers
   output logic             xfer_done,
   output logic             xfer_count_zero,
   output logic             cpu_ack,
   output logic             instr_end
);
   logic [3:0] xcnt_q;
   logic [3:0] acnt_q;
   logic [1:0] icnt_q;

   // one beat per answer; latency never below 2 so a held request is not answered twice
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         xcnt_q          <= 4'h0;
         acnt_q          <= 4'h0;
         icnt_q          <= 2'h0;
         xfer_done       <= 1'b0;
         xfer_count_zero <= 1'b0;
         cpu_ack         <= 1'b0;
         instr_end       <= 1'b0;
      end else begin
         icnt_q          <= icnt_q + 2'h1;
         instr_end       <= (icnt_q == 2'h3);
         xfer_done       <= 1'b0;
         cpu_ack         <= 1'b0;
         xfer_count_zero <= ~count_zero_cfg; // only meaningful beside the done beat
         if (xfer_req && !xfer_done) begin
            xcnt_q <= (xcnt_q == lat) ? 4'h0 : xcnt_q + 4'h1;
            if (xcnt_q == lat) begin
               xfer_done       <= 1'b1;
               xfer_count_zero <= count_zero_cfg;
            end
         end else begin
            xcnt_q <= 4'h0;
         end
         if (cpu_req && !cpu_ack) begin
            acnt_q  <= (acnt_q == lat) ? 4'h0 : acnt_q + 4'h1;
            cpu_ack <= (acnt_q == lat);
         end else begin
            acnt_q <= 4'h0;
         end
      end
   end
endmodule

// ### dv/test_interrupt_dispatch_transfer_routing.sv
/*
  Self-checking bench for the interrupt dispatch block: every routing code,
  fixed engine priority, block-move refusal, flag clearing and mask state.
  Assumes the far-side model irq_far_side and the shared package.
*/
`timescale 1ns/1ps
module test_interrupt_dispatch_transfer_routing
   import irq_dispatch_pkg::*;
;
   logic clk_sys, rst;
   logic [NUM_SRC-1:0] pin_req, int_set, src_is_pin, int_enable, level_one, flag_clr;
   logic [NUM_SRC-1:0] transfer_activation_enable, enable_set, cpu_request_after_transfer;
   logic three_level_mode, mask_wr, mask_i_new, mask_ui_new, instr_end, ctrl_instr;
   logic block_move_byte_count, block_move_word_count, word_move_break;
   logic [1:0] acc_kind;
   logic acc_three_state;
   logic [3:0] acc_wait, lat, xfer_src;
   logic xfer_done, xfer_count_zero, xfer_req, cpu_ack, cpu_req, exc_busy, count_zero_cfg;
   logic [VEC_W-1:0] cpu_vector;
   logic [NUM_SRC-1:0] flags, enable_out;
   logic mask_i, secondary_interrupt_mask;
   logic [11:0] notes[$];
   logic [31:0] seed;
   int num_errors, total_checks;

   irq_dispatch dut (.clk_sys(clk_sys), .rst(rst), .pin_req(pin_req), .int_set(int_set),
      .src_is_pin(src_is_pin), .int_enable(int_enable), .level_one(level_one), .flag_clr(flag_clr),
      .transfer_activation_enable(transfer_activation_enable), .enable_set(enable_set),
      .cpu_request_after_transfer(cpu_request_after_transfer), .three_level_mode(three_level_mode),
      .mask_wr(mask_wr), .mask_i_new(mask_i_new), .mask_ui_new(mask_ui_new), .instr_end(instr_end),
      .ctrl_instr(ctrl_instr), .block_move_byte_count(block_move_byte_count),
      .block_move_word_count(block_move_word_count), .word_move_break(word_move_break),
      .acc_kind(acc_kind), .acc_three_state(acc_three_state), .acc_wait(acc_wait),
      .xfer_done(xfer_done), .xfer_count_zero(xfer_count_zero), .xfer_req(xfer_req),
      .xfer_src(xfer_src), .cpu_ack(cpu_ack), .cpu_req(cpu_req), .cpu_vector(cpu_vector),
      .exc_busy(exc_busy), .flags(flags), .enable_out(enable_out), .mask_i(mask_i),
      .secondary_interrupt_mask(secondary_interrupt_mask));

   irq_far_side far (.clk_sys(clk_sys), .rst(rst), .xfer_req(xfer_req), .cpu_req(cpu_req),
      .lat(lat), .count_zero_cfg(count_zero_cfg), .xfer_done(xfer_done),
      .xfer_count_zero(xfer_count_zero), .cpu_ack(cpu_ack), .instr_end(instr_end));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
   endfunction

   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic take(input logic [11:0] got);
      if (notes.size() == 0)
         check(got, 12'hfff);
      else
         check(got, notes.pop_front());
   endtask

   // results are judged at the handshake beat, so a held request counts once
   always @(negedge clk_sys) begin
      if (!rst && xfer_done === 1'b1 && xfer_req === 1'b1) take({4'hd, 4'h0, xfer_src});
      if (!rst && cpu_ack === 1'b1 && cpu_req === 1'b1) take({4'hc, cpu_vector});
   end

   task automatic drain;
      int n;
      n = 0;
      while ((notes.size() != 0 || cpu_req !== 1'b0 || xfer_req !== 1'b0 || exc_busy !== 1'b0) && n < 600) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 600) num_errors++; // a hung handshake is a mismatch
      repeat (8) @(negedge clk_sys);
   endtask

   task automatic run_case(input logic [3:0] src, input logic te, input logic aft, input logic cz,
                           input logic blk);
      logic [31:0] r;
      r = xs(seed);
      seed = r;
      lat = r[3:0] | 4'h2; // slow and prompt answers both occur
      acc_kind = (r[5:4] == 2'h3) ? 2'h1 : r[5:4];
      acc_three_state = r[6];
      acc_wait = r[10:7];
      three_level_mode = r[11];
      {block_move_word_count, word_move_break} = {2{r[13]}};
      count_zero_cfg = cz;
      mask_wr = 1'b1;
      mask_i_new = 1'b0;
      mask_ui_new = 1'b0;
      @(negedge clk_sys);
      mask_wr = 1'b0;
      repeat (4) @(negedge clk_sys);
      transfer_activation_enable[src] = te;
      cpu_request_after_transfer[src] = aft;
      enable_set[src] = 1'b1;
      @(negedge clk_sys);
      enable_set = '0;
      if (te) notes.push_back({4'hd, 4'h0, src});
      if (!te || aft || cz) notes.push_back({4'hc, 4'h0, src});
      block_move_byte_count = blk;
      src_is_pin[src] = blk;
      if (blk) pin_req[src] = 1'b1;
      else int_set[src] = 1'b1;
      @(negedge clk_sys);
      int_set = '0;
      // control instruction ends on exactly one end beat while the request waits
      if (r[12]) begin
         while (instr_end !== 1'b1) @(negedge clk_sys);
         ctrl_instr = 1'b1;
         @(negedge clk_sys);
         ctrl_instr = 1'b0;
      end
      repeat (5) @(negedge clk_sys);
      pin_req = '0;
      if (blk) begin
         repeat (40) begin
            @(negedge clk_sys);
            check({11'h0, cpu_req}, 12'h000);
         end
         block_move_byte_count = 1'b0;
      end
      drain();
      if (!cz) check({11'h0, flags[src]}, {11'h0, !te || aft});
      check({11'h0, enable_out[src]}, {11'h0, te && !aft && !cz});
      if ((!te || aft || cz) && three_level_mode)
         check({10'h0, mask_i, secondary_interrupt_mask}, 12'h003);
      else if (!te || aft || cz)
         check({11'h0, mask_i}, 12'h001);
      flag_clr[src] = 1'b1;
      @(negedge clk_sys);
      flag_clr = '0;
      repeat (8) @(negedge clk_sys);
      check({11'h0, flags[src]}, 12'h000);
      src_is_pin = '0;
      {block_move_word_count, word_move_break} = 2'b00;
      transfer_activation_enable[src] = 1'b0;
      enable_set[src] = 1'b1;
      @(negedge clk_sys);
      enable_set = '0;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      conclude();
   end

   initial begin
      logic [31:0] r;
      rst = 1'b1;
      {pin_req, int_set, src_is_pin, level_one, flag_clr, enable_set} = '0;
      {transfer_activation_enable, cpu_request_after_transfer} = '0;
      int_enable = '1;
      {three_level_mode, mask_wr, mask_i_new, mask_ui_new, ctrl_instr} = '0;
      {block_move_byte_count, block_move_word_count, word_move_break} = '0;
      {acc_kind, acc_three_state, acc_wait, count_zero_cfg} = '0;
      lat = 4'h2;
      seed = 32'h2fa701da;
      num_errors = 0;
      total_checks = 0;
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      check({xfer_req, cpu_req, mask_i, secondary_interrupt_mask}, 12'h002);
      check({flags[7:0], enable_out[3:0]}, 12'h000);
      // engine pick with the mask still set after reset: lower index first
      transfer_activation_enable[2] = 1'b1;
      transfer_activation_enable[6] = 1'b1;
      enable_set = 16'h0044;
      @(negedge clk_sys);
      enable_set = '0;
      notes.push_back(12'hd02);
      notes.push_back(12'hd06);
      int_set = 16'h0044;
      @(negedge clk_sys);
      int_set = '0;
      drain();
      check({10'h0, flags[6], flags[2]}, 12'h000);
      transfer_activation_enable = '0;
      enable_set = 16'h0044;
      @(negedge clk_sys);
      enable_set = '0;
      // every routing code, random sources
      for (int i = 0; i < 8; i++) begin
         r = xs(seed);
         seed = r;
         run_case(r[3:0], (i % 4) != 0, (i % 4) == 2, (i % 4) == 3, 1'b0);
      end
      run_case(4'h4, 1'b0, 1'b0, 1'b0, 1'b1);
      conclude();
   end
endmodule

// ### shared/irq_dispatch_pkg.sv
/*
  Constants and types shared by the interrupt dispatch block: source count,
  response-time state costs, timing counts and the dispatch state encoding.
  Assumes a single system clock domain at 100 MHz.
*/
// Operation
// R1 - external requests take 3 states of priority determination, internal ones 2
// R2 - acceptance waits for instruction end, adding 1 to 19 plus two fetches
// R3 - accepted request costs stack save, vector fetch, prefetch and 2 internal states
// R4 - access cost: internal 1, 8-bit 4 or 6+2m, 16-bit 2 or 3+m
// R5 - each source may go to processor, transfer engine or both
// R6 - activation enable 0: processor only, flag left for the handler
// R7 - enable 1, after-transfer bit 0: engine only, flag cleared automatically
// R8 - enable 1, after-transfer bit 1: after transfer clear enable, request processor
// R9 - engine count reaching zero clears enable and requests the processor
// R10 - engine source chosen by fixed default priority, masks and levels ignored
// R11 - source routed to both: transfer completes before processor exception handling
// R12 - enable or flag clear takes effect only after the clearing instruction ends; here only the flag clear waits, enable_set applies at once
// R13 - in that conflict a higher-priority pending request wins, the lower is dropped
// R14 - after control load or logical ops, block all interrupts for one instruction
// R15 - a mask bit set by such an instruction applies two states after it ends
// R16 - byte-count block move accepts no interrupt until the move finishes
// R17 - word-count block move may break between transfers, saving next address
// R18 - pin request flags may be set after reset from pin levels
// R19 - three-level mode acceptance sets both mask bits to one
// R20 - hold accepted request and vector until processor acknowledges, then drop it
package irq_dispatch_pkg;
   localparam int          NUM_SRC          = 16;
   localparam int          VEC_W            = 8;
   localparam int          CLK_NS           = 10;
   // priority determination states
   localparam logic [2:0]  PRIO_EXT_STATES  = 3'h3;
   localparam logic [2:0]  PRIO_INT_STATES  = 3'h2;
   // instruction-end wait worst case, internal processing, mask delay
   localparam logic [4:0]  INSTR_WAIT_MAX   = 5'h13;
   localparam logic [2:0]  INTERNAL_STATES  = 3'h2;
   localparam logic [1:0]  MASK_DELAY       = 2'h2;
   // access cost per exception access
   localparam logic [4:0]  COST_INTERNAL    = 5'h01;
   localparam logic [4:0]  COST_B8_2ST      = 5'h04;
   localparam logic [4:0]  COST_B8_3ST_BASE = 5'h06;
   localparam logic [4:0]  COST_B16_2ST     = 5'h02;
   localparam logic [4:0]  COST_B16_3ST_BASE= 5'h03;
   localparam logic [1:0]  ACC_INTERNAL     = 2'h0;
   localparam logic [1:0]  ACC_BUS8         = 2'h1;
   localparam logic [1:0]  ACC_BUS16        = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_PRIO  = 3'b001,
      ST_XFER  = 3'b010,
      ST_OFFER = 3'b011,
      ST_EXC   = 3'b100
   } disp_state_t;
endpackage

// ### verilog/irq_cost_calc.sv
/*
  Exception access cost in states per access type and wait count.
  Assumes the bus width and state selection are static during exceptions.
*/
`timescale 1ns/1ps
module irq_cost_calc
   import irq_dispatch_pkg::*;
(
   // access selection
   input  wire logic [1:0]  acc_kind,
   input  wire logic        three_state,
   input  wire logic [3:0]  wait_cnt,
   // cost of one access; six bits since 6 + 2m reaches 36 at fifteen waits
   output logic [5:0]       cost
);
   always_comb begin
      case (acc_kind)
         ACC_INTERNAL: cost = {1'b0, COST_INTERNAL};                                 // R4
         ACC_BUS8:     cost = three_state ? 6'(COST_B8_3ST_BASE) + {1'b0, wait_cnt, 1'b0} // R4
                                          : {1'b0, COST_B8_2ST};
         ACC_BUS16:    cost = three_state ? 6'(COST_B16_3ST_BASE) + {2'b00, wait_cnt}  // R4
                                          : {1'b0, COST_B16_2ST};
         default:      cost = {1'b0, COST_INTERNAL};
      endcase
   end
endmodule

// ### verilog/irq_dispatch.sv
/*
  Interrupt dispatch: routes source flags to the transfer engine and/or the
  processor, models the response-time budget with a state counter, and
  handles mask, instruction-boundary and block-move gating.
  Assumes the core reports instruction ends, block-move phases and mask
  writes as same-clock pulses/levels; pin sources pass a 2-flop sync.
*/
`timescale 1ns/1ps
module irq_dispatch
   import irq_dispatch_pkg::*;
#(
   parameter int N = NUM_SRC
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // sources: pin levels and internal set pulses
   input  wire logic [N-1:0]      pin_req,
   input  wire logic [N-1:0]      int_set,
   input  wire logic [N-1:0]      src_is_pin,
   input  wire logic [N-1:0]      int_enable,
   input  wire logic [N-1:0]      level_one,
   input  wire logic [N-1:0]      flag_clr,
   // routing control
   input  wire logic [N-1:0]      transfer_activation_enable,
   input  wire logic [N-1:0]      enable_set,
   input  wire logic [N-1:0]      cpu_request_after_transfer,
   // mask control from the core
   input  wire logic              three_level_mode,
   input  wire logic              mask_wr,
   input  wire logic              mask_i_new,
   input  wire logic              mask_ui_new,
   // instruction boundaries
   input  wire logic              instr_end,
   input  wire logic              ctrl_instr,
   input  wire logic              block_move_byte_count,
   input  wire logic              block_move_word_count,
   input  wire logic              word_move_break,
   // access cost selection
   input  wire logic [1:0]        acc_kind,
   input  wire logic              acc_three_state,
   input  wire logic [3:0]        acc_wait,
   // transfer engine handshake
   input  wire logic              xfer_done,
   input  wire logic              xfer_count_zero,
   output logic                   xfer_req,
   output logic [$clog2(N)-1:0]   xfer_src,
   // processor handshake
   input  wire logic              cpu_ack,
   output logic                   cpu_req,
   output logic [VEC_W-1:0]       cpu_vector,
   output logic                   exc_busy,
   // status
   output logic [N-1:0]           flags,
   output logic [N-1:0]           enable_out,
   output logic                   mask_i,
   output logic                   secondary_interrupt_mask
);
   localparam int IW = $clog2(N);

   // pin synchroniser
   logic [N-1:0] pin_s1_q, pin_s2_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= pin_req;
         pin_s2_q <= pin_s1_q;
      end
   end

   // per-source flag and enable state
   logic [N-1:0] flag_q, flag_d, en_q, en_d, auto_clr, en_clr, clr_pend_q, clr_pend_d;
   logic [N-1:0] eff_flag;
   disp_state_t  st_q, st_d;
   logic [IW-1:0] cur_q, cur_d;
   logic         cur_cpu_q, cur_cpu_d;

   // flag clears wait for instruction end; a same-cycle set wins the flag, but en_clr wins over enable_set
   generate
      for (genvar g = 0; g < N; g++) begin : g_src
         always_comb begin
            // a clear arriving on an end beat waits for the next end instead of being lost
            clr_pend_d[g] = (clr_pend_q[g] & ~instr_end) | flag_clr[g];            // R12
            flag_d[g] = flag_q[g];
            if (clr_pend_q[g] & instr_end)
               flag_d[g] = 1'b0;
            if (auto_clr[g])
               flag_d[g] = 1'b0;                                                   // R7
            if (src_is_pin[g] ? pin_s2_q[g] : int_set[g])
               flag_d[g] = 1'b1;                                                   // R18
            en_d[g] = en_q[g];
            if (enable_set[g])
               en_d[g] = transfer_activation_enable[g];
            if (en_clr[g])
               en_d[g] = 1'b0;                                                     // R8 R9
         end
      end
   endgenerate

   // flag stays visible until the clearing instruction has ended
   assign eff_flag = flag_q & int_enable;

   // engine candidates: fixed order, masks ignored
   logic [N-1:0] eng_req, cpu_cand;
   logic         eng_any, cpu_any;
   logic [IW-1:0] eng_idx, cpu_idx;
   assign eng_req = eff_flag & en_q;                                               // R5 R10
   irq_prio_pick #(.N(N)) u_eng (.req(eng_req), .any(eng_any), .idx(eng_idx));

   // mask gating with delayed mask update
   logic i_q, i_d, ui_q, ui_d, pend_i_q, pend_i_d, pend_ui_q, pend_ui_d;
   logic [1:0] mdly_q, mdly_d;
   logic blk_q, blk_d;
   logic [N-1:0] lvl_ok, cpu_lvl1, cpu_lvl0;
   always_comb begin
      for (int k = 0; k < N; k++) begin
         lvl_ok[k] = ~i_q | (three_level_mode & level_one[k] & ~ui_q);
      end
      cpu_cand = eff_flag & ~en_q & lvl_ok;                                        // R6
      // control level 1 beats level 0, then fixed order picks the winner
      cpu_lvl1 = cpu_cand & level_one;
      cpu_lvl0 = (|cpu_lvl1) ? cpu_lvl1 : cpu_cand;                                // R13
   end
   irq_prio_pick #(.N(N)) u_cpu (.req(cpu_lvl0), .any(cpu_any), .idx(cpu_idx));

   // access cost and state budget
   logic [5:0] acc_cost;
   irq_cost_calc u_cost (
      .acc_kind    (acc_kind),
      .three_state (acc_three_state),
      .wait_cnt    (acc_wait),
      .cost        (acc_cost)
   );
   logic [7:0] cnt_q, cnt_d;
   logic [2:0] phase_q, phase_d;

   // boundary where a new request may be taken
   logic take_ok;
   // no boundary right after a control instruction; its successor always runs
   assign take_ok = (instr_end | (block_move_word_count & word_move_break & ~blk_q)) // R2 R17
                    & ~(ctrl_instr & instr_end) & ~block_move_byte_count;          // R14 R16

   // mask delay and blocking after control instructions
   always_comb begin
      i_d = i_q;
      ui_d = ui_q;
      pend_i_d = pend_i_q;
      pend_ui_d = pend_ui_q;
      mdly_d = mdly_q;
      blk_d = blk_q;
      if (ctrl_instr & instr_end)
         blk_d = 1'b1;                                                             // R14
      else if (blk_q & instr_end)
         blk_d = 1'b0;
      if (mdly_q != 2'h0) begin
         mdly_d = 2'(mdly_q - 2'h1);
         if (mdly_q == 2'h1) begin
            i_d = pend_i_q;                                                        // R15
            ui_d = pend_ui_q;
         end
      end
      if (mask_wr) begin
         pend_i_d = mask_i_new;
         pend_ui_d = mask_ui_new;
         mdly_d = MASK_DELAY;                                                      // R15
      end
      if (st_q == ST_OFFER && cpu_ack) begin
         i_d = 1'b1;
         if (three_level_mode)
            ui_d = 1'b1;                                                           // R19
      end
   end

   // dispatch sequencer
   always_comb begin
      st_d = st_q;
      cur_d = cur_q;
      cur_cpu_d = cur_cpu_q;
      cnt_d = cnt_q;
      phase_d = phase_q;
      auto_clr = '0;
      en_clr = '0;
      case (st_q)
         ST_IDLE: begin
            if (eng_any) begin
               cur_d = eng_idx;
               st_d = ST_XFER;
            end else if (cpu_any) begin
               cur_d = cpu_idx;
               cnt_d = {5'h00, src_is_pin[cpu_idx] ? PRIO_EXT_STATES : PRIO_INT_STATES}; // R1
               st_d = ST_PRIO;
            end
         end
         ST_PRIO: begin
            if (cnt_q > 8'h01)
               cnt_d = 8'(cnt_q - 8'h01);
            else if (take_ok)
               st_d = ST_OFFER;
         end
         ST_XFER: begin
            if (xfer_done) begin
               if (xfer_count_zero | cpu_request_after_transfer[cur_q]) begin
                  en_clr[cur_q] = 1'b1;                                            // R8 R9
                  cnt_d = {5'h00, src_is_pin[cur_q] ? PRIO_EXT_STATES : PRIO_INT_STATES};
                  st_d = ST_PRIO;                                                  // R11
               end else begin
                  auto_clr[cur_q] = 1'b1;                                          // R7
                  st_d = ST_IDLE;
               end
            end
         end
         ST_OFFER: begin
            if (cpu_ack) begin                                                     // R20
               cnt_d = 8'({acc_cost, 1'b0});
               phase_d = 3'h0;
               st_d = ST_EXC;
            end
         end
         ST_EXC: begin
            // stack save, vector fetch, prefetch, then internal processing
            if (cnt_q > 8'h01)
               cnt_d = 8'(cnt_q - 8'h01);
            else if (phase_q < 3'h2) begin
               phase_d = 3'(phase_q + 3'h1);
               cnt_d = 8'({acc_cost, 1'b0});                                       // R3
            end else if (phase_q == 3'h2) begin
               phase_d = 3'h3;
               cnt_d = {5'h00, INTERNAL_STATES};                                   // R3
            end else
               st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // register all state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flag_q <= '0;
         en_q <= '0;
         clr_pend_q <= '0;
         st_q <= ST_IDLE;
         cur_q <= '0;
         cur_cpu_q <= 1'b0;
         cnt_q <= 8'h00;
         phase_q <= 3'h0;
         i_q <= 1'b1;
         ui_q <= 1'b0;
         pend_i_q <= 1'b1;
         pend_ui_q <= 1'b0;
         mdly_q <= 2'h0;
         blk_q <= 1'b0;
         xfer_req <= 1'b0;
         xfer_src <= '0;
         cpu_req <= 1'b0;
         cpu_vector <= '0;
         exc_busy <= 1'b0;
      end else begin
         flag_q <= flag_d;
         en_q <= en_d;
         clr_pend_q <= clr_pend_d;
         st_q <= st_d;
         cur_q <= cur_d;
         cur_cpu_q <= cur_cpu_d;
         cnt_q <= cnt_d;
         phase_q <= phase_d;
         i_q <= i_d;
         ui_q <= ui_d;
         pend_i_q <= pend_i_d;
         pend_ui_q <= pend_ui_d;
         mdly_q <= mdly_d;
         blk_q <= blk_d;
         xfer_req <= (st_d == ST_XFER);
         xfer_src <= cur_d;
         cpu_req <= (st_d == ST_OFFER);                                            // R20
         cpu_vector <= VEC_W'(cur_d);
         exc_busy <= (st_d == ST_EXC);
      end
   end

   assign flags = flag_q;
   assign enable_out = en_q;
   assign mask_i = i_q;
   assign secondary_interrupt_mask = ui_q;

   // checks
   a_req_hold: assert property (@(posedge clk_sys) disable iff (rst)
      cpu_req && !cpu_ack |=> cpu_req && $stable(cpu_vector))                      // R20
      else $error("request dropped before ack");
   a_ack_drop: assert property (@(posedge clk_sys) disable iff (rst)
      cpu_req && cpu_ack |=> !cpu_req)                                             // R20
      else $error("request held after ack");
   a_xfer_first: assert property (@(posedge clk_sys) disable iff (rst)
      xfer_req |-> !cpu_req)                                                       // R11
      else $error("processor request during transfer");
   a_auto_clear: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == ST_XFER && xfer_done && !xfer_count_zero && !cpu_request_after_transfer[cur_q]
      && !(src_is_pin[cur_q] ? pin_s2_q[cur_q] : int_set[cur_q]) |=> !flag_q[$past(cur_q)]) // R7
      else $error("flag not auto cleared");
   a_zero_clears: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == ST_XFER && xfer_done && xfer_count_zero && !enable_set[cur_q]
      |=> !en_q[$past(cur_q)] ##0 st_q == ST_PRIO)                                 // R9
      else $error("enable not cleared at zero count");
   a_byte_move: assert property (@(posedge clk_sys) disable iff (rst)
      block_move_byte_count && st_q == ST_PRIO |=> st_q != ST_OFFER)               // R16
      else $error("accept during byte move");
   a_ctrl_block: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_instr && instr_end |=> blk_q)                                           // R14
      else $error("no block after control instruction");
   a_ctrl_no_take: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_instr && instr_end && st_q == ST_PRIO |=> st_q == ST_PRIO)             // R14
      else $error("accept at control instruction end");
   a_mask_delay: assert property (@(posedge clk_sys) disable iff (rst)
      mask_wr && !cpu_ack ##1 !mask_wr && !(st_q == ST_OFFER && cpu_ack)
      ##1 !mask_wr && !(st_q == ST_OFFER && cpu_ack) |=> i_q == $past(pend_i_q))   // R15
      else $error("mask not applied after delay");
   a_three_level: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == ST_OFFER && cpu_ack && three_level_mode |=> i_q && ui_q)             // R19
      else $error("masks not set on accept");
   a_prio_ext: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == ST_IDLE && !eng_any && cpu_any && src_is_pin[cpu_idx]
      |=> st_q == ST_PRIO [*2])                                                    // R1
      else $error("external prio too short");
   c_cpu_only: cover property (@(posedge clk_sys) disable iff (rst) cpu_req && cpu_ack);
   c_xfer_then_cpu: cover property (@(posedge clk_sys) disable iff (rst)
      xfer_req ##[1:20] cpu_req);
   c_exc_done: cover property (@(posedge clk_sys) disable iff (rst)
      exc_busy ##1 !exc_busy);
endmodule

// ### verilog/irq_prio_pick.sv
/*
  Fixed default priority picker: lowest index wins.
  Assumes pure combinational use inside one clock domain.
*/
`timescale 1ns/1ps
module irq_prio_pick
   import irq_dispatch_pkg::*;
#(
   parameter int N = NUM_SRC
) (
   // request vector
   input  wire logic [N-1:0]         req,
   // winner
   output logic                      any,
   output logic [$clog2(N)-1:0]      idx
);
   // scan from highest index so the lowest index is left standing
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = N-1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = ($clog2(N))'(i);
         end
      end
   end
endmodule
